//--- hw/opc_pkg.sv
// Package for the amplifier control register bank
package opc_pkg;
   localparam int          NUM_AMPS       = 2;
   localparam logic [11:0] AMP1_CTRL_OFFS = 12'h000;
   localparam logic [11:0] AMP2_CTRL_OFFS = 12'h004;
   localparam int          ENABLE_BIT     = 7;
   localparam int          SPEED_BIT      = 6;
   localparam int          UNITY_BIT      = 4;
   localparam int          CHAN_LSB       = 0;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam logic [7:0]  CTRL_IMPL_MASK = 8'hd3;
   localparam logic [1:0]  CHAN_FIXED_REF = 2'h3;
   localparam logic [1:0]  CHAN_RESERVED  = 2'h2;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Static settings handed to one analog amplifier
   typedef struct packed {
      logic       enable;
      logic       high_speed;
      logic       unity_feedback;
      logic       inv_pin_released;
      logic       out_driver_tristate;
      logic [1:0] noninv_channel_select;
      logic       fixed_ref_select;
   } opc_amp_cfg_t;
endpackage

//--- hw/opc_regs.sv
// AXI4-Lite register bank driving two amplifier control settings
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Enable bit 7 switches the amplifier on; cleared means no active power.
// - Bit 6 set selects the high gain-bandwidth mode.
// - Unity bit set feeds output back and frees the inverting pin.
// - Unity bit clear connects the inverting input to its external pin.
// - Bits 5 and 3-2 always read as zero.
// - Reset clears every control register, leaving amplifiers disabled.
// - Enabled amplifier tristates the pin's normal digital output driver.
module opc_regs (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output var  logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output var  logic                 s_axi_wready,
   output var  logic [1:0]           s_axi_bresp,
   output var  logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output var  logic                 s_axi_arready,
   output var  logic [31:0]          s_axi_rdata,
   output var  logic [1:0]           s_axi_rresp,
   output var  logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output var  opc_pkg::opc_amp_cfg_t amp1_cfg,
   output var  opc_pkg::opc_amp_cfg_t amp2_cfg
);
   logic [7:0]  ctrl_q [2];
   logic [7:0]  ctrl_d [2];
   logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [11:0] awaddr_q, awaddr_d;
   logic [7:0]  wbyte_q, wbyte_d;
   logic        wlane_q, wlane_d;
   logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   opc_pkg::opc_amp_cfg_t cfg_q [2];
   opc_pkg::opc_amp_cfg_t cfg_d [2];
   logic        awready_q, awready_d, wready_q, wready_d;
   logic        arready_q, arready_d;

   function automatic opc_pkg::opc_amp_cfg_t decode(input logic [7:0] r);
      opc_pkg::opc_amp_cfg_t c;
      c = '0;
      c.enable                = r[opc_pkg::ENABLE_BIT];
      c.high_speed            = r[opc_pkg::SPEED_BIT];
      c.unity_feedback        = r[opc_pkg::UNITY_BIT];
      c.inv_pin_released      = r[opc_pkg::UNITY_BIT];
      c.out_driver_tristate   = r[opc_pkg::ENABLE_BIT];
      c.noninv_channel_select = r[opc_pkg::CHAN_LSB +: 2];
      c.fixed_ref_select      =
         (r[opc_pkg::CHAN_LSB +: 2] == opc_pkg::CHAN_FIXED_REF);
      return c;
   endfunction

   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d  = w_held_q;
      awaddr_d  = awaddr_q;
      wbyte_d   = wbyte_q;
      wlane_d   = wlane_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      ctrl_d    = ctrl_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_d = 1'b1;
         wbyte_d  = s_axi_wdata[7:0];
         wlane_d  = s_axi_wstrb[0];
      end
      if (aw_held_q && w_held_q && !bvalid_q) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = opc_pkg::RESP_OKAY;
         if (awaddr_q == opc_pkg::AMP1_CTRL_OFFS) begin
            if (wlane_q)
               ctrl_d[0] = wbyte_q & opc_pkg::CTRL_IMPL_MASK;
         end else if (awaddr_q == opc_pkg::AMP2_CTRL_OFFS) begin
            if (wlane_q)
               ctrl_d[1] = wbyte_q & opc_pkg::CTRL_IMPL_MASK;
         end else begin
            bresp_d = opc_pkg::RESP_SLVERR;
         end
      end
      if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = opc_pkg::RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         if (s_axi_araddr == opc_pkg::AMP1_CTRL_OFFS)
            rdata_d[7:0] = ctrl_q[0] & opc_pkg::CTRL_IMPL_MASK;
         else if (s_axi_araddr == opc_pkg::AMP2_CTRL_OFFS)
            rdata_d[7:0] = ctrl_q[1] & opc_pkg::CTRL_IMPL_MASK;
         else
            rresp_d = opc_pkg::RESP_SLVERR;
      end
      for (int i = 0; i < opc_pkg::NUM_AMPS; i++)
         cfg_d[i] = decode(ctrl_d[i]);
      // Readies are registered so that every bus output leaves a flip-flop
      awready_d = ~aw_held_d & ~bvalid_d;
      wready_d  = ~w_held_d & ~bvalid_d;
      arready_d = ~rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q[0] <= opc_pkg::CTRL_RESET;
         ctrl_q[1] <= opc_pkg::CTRL_RESET;
         cfg_q[0]  <= '0;
         cfg_q[1]  <= '0;
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 12'h000;
         wbyte_q   <= 8'h00;
         wlane_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
         rvalid_q  <= 1'b0;
         rresp_q   <= 2'h0;
         rdata_q   <= 32'h0000_0000;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         cfg_q     <= cfg_d;
         aw_held_q <= aw_held_d;
         w_held_q  <= w_held_d;
         awaddr_q  <= awaddr_d;
         wbyte_q   <= wbyte_d;
         wlane_q   <= wlane_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         arready_q <= arready_d;
      end
   end

   // Ready only while nothing of that channel is held, so capture is single;
   // registering it costs one idle cycle after reset
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_arready = arready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign amp1_cfg      = cfg_q[0];
   assign amp2_cfg      = cfg_q[1];

   a_enable_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      amp1_cfg.enable == ctrl_q[0][7])
      else $error("amp1 enable differs from control bit 7");
   a_tristate_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      amp2_cfg.out_driver_tristate == ctrl_q[1][7])
      else $error("amp2 output driver not tristated while enabled");
   a_speed_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      amp1_cfg.high_speed == ctrl_q[0][6])
      else $error("amp1 speed differs from control bit 6");
   a_unity_release: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_q[0][4] |-> amp1_cfg.unity_feedback && amp1_cfg.inv_pin_released)
      else $error("inverting pin held under unity feedback");
   a_unity_external: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_q[1][4] |-> !amp2_cfg.unity_feedback && !amp2_cfg.inv_pin_released)
      else $error("amp2 inverting input not on external pin");
   a_channel_decode: assert property (@(posedge aclk) disable iff (!aresetn)
      amp1_cfg.fixed_ref_select == (ctrl_q[0][1:0] == 2'h3))
      else $error("fixed reference select wrong");
   a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata & 32'hffff_ff2c) == 32'h0000_0000)
      else $error("unimplemented bits read non-zero");
   a_reset_clears: assert property (@(posedge aclk)
      !aresetn |=> ctrl_q[0] == 8'h00 && ctrl_q[1] == 8'h00 && !amp1_cfg.enable)
      else $error("reset left control register set");
   a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
      aw_held_q && w_held_q && !bvalid_q && wlane_q
      && awaddr_q == 12'h000 |=> ctrl_q[0] == ($past(wbyte_q) & 8'hd3)
      ##1 amp1_cfg.enable == $past(wbyte_q[7], 2))
      else $error("written amp1 value not stored");
   a_enable_two: assert property (@(posedge aclk) disable iff (!aresetn)
      amp2_cfg.enable == ctrl_q[1][7])
      else $error("amp2 enable differs from control bit 7");
   a_channel_raw: assert property (@(posedge aclk) disable iff (!aresetn)
      amp2_cfg.noninv_channel_select == ctrl_q[1][1:0])
      else $error("amp2 channel select differs from control field");
   a_settings_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !(aw_held_q && w_held_q && !bvalid_q) |=> $stable(ctrl_q[0])
      && $stable(ctrl_q[1]) && $stable(amp1_cfg) && $stable(amp2_cfg))
      else $error("control settings changed without a write");
   a_single_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel ready while a response is pending");
endmodule // opc_regs
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the amplifier control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                  aclk    = 1'b0;
   logic                  aresetn = 1'b0;
   logic [11:0]           awaddr  = 12'h000;
   logic [11:0]           araddr  = 12'h000;
   logic [31:0]           wdata   = 32'h0000_0000;
   logic [3:0]            wstrb   = 4'h0;
   logic                  awvalid = 1'b0;
   logic                  wvalid  = 1'b0;
   logic                  bready  = 1'b0;
   logic                  arvalid = 1'b0;
   logic                  rready  = 1'b0;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [1:0]            bresp, rresp, resp;
   logic [31:0]           rdata, rd;
   opc_pkg::opc_amp_cfg_t cfg1, cfg2;
   int                    error_cnt = 0;
   int                    compares = 0;
   int                    cyc = 0;
   logic [7:0]            e1, e2;
   // Rows hold {written, read back}; masked bits and code 10 mixed in
   // speed bit kept set
   logic [15:0] rows [7] = '{16'hffd3, 16'hd3d3, 16'h4040, 16'h6e42,
                             16'hf5d1, 16'hc0c0, 16'h4040};

   always #20 aclk = ~aclk;

   opc_regs i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .amp1_cfg(cfg1), .amp2_cfg(cfg2));

   task automatic fail(input string m);
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) fail($sformatf("rdata %h exp %h", g, e));
   endtask
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      compares++;
      if (g !== e) fail($sformatf("resp %h exp %h", g, e));
   endtask
   task automatic chk_cfg(input opc_pkg::opc_amp_cfg_t g,
                          input opc_pkg::opc_amp_cfg_t e);
      compares++;
      if (g !== e) fail($sformatf("cfg %h exp %h", g, e));
   endtask
   // Tristate and pin release follow enable and unity directly
   function automatic opc_pkg::opc_amp_cfg_t ecfg(input logic [7:0] v);
      return {v[7], v[6], v[4], v[4], v[7], v[1:0], v[1:0] == 2'h3};
   endfunction

   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 50);
      r = bresp;
      bready <= 1'b0;
      if (n >= 50) fail("write hang");
      // Let an edge pass so a following call never re-drives bready at once
      @(posedge aclk);
   endtask
   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 50) fail("read hang");
      @(posedge aclk);
   endtask

   task automatic final_report;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Cut a hang short well past the expected hundred or so cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail("timeout");
         final_report();
      end
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_cfg(cfg1, '0);
      e1 = 8'h00;
      e2 = 8'h00;
      foreach (rows[i]) begin
         if (i[0]) e2 = rows[i][7:0];
         else e1 = rows[i][7:0];
         wr(i[0] ? opc_pkg::AMP2_CTRL_OFFS : opc_pkg::AMP1_CTRL_OFFS,
            rows[i][15:8], 4'h1, resp);
         chk_resp(resp, opc_pkg::RESP_OKAY);
         chk_cfg(cfg1, ecfg(e1));
         chk_cfg(cfg2, ecfg(e2));
         rd_reg(i[0] ? opc_pkg::AMP2_CTRL_OFFS : opc_pkg::AMP1_CTRL_OFFS,
                rd, resp);
         chk_resp(resp, opc_pkg::RESP_OKAY);
         chk_data(rd, {24'h00_0000, i[0] ? e2 : e1});
      end
      // Unmapped word and a strobe-less write must leave settings alone
      wr(12'h008, 8'hff, 4'h1, resp);
      chk_resp(resp, opc_pkg::RESP_SLVERR);
      rd_reg(12'h008, rd, resp);
      chk_resp(resp, opc_pkg::RESP_SLVERR);
      chk_data(rd, 32'h0000_0000);
      wr(opc_pkg::AMP1_CTRL_OFFS, 8'hff, 4'h0, resp);
      chk_resp(resp, opc_pkg::RESP_OKAY);
      chk_cfg(cfg1, ecfg(e1));
      chk_cfg(cfg2, ecfg(e2));
      // Reset in mid-run after both amplifiers were switched on
      wr(opc_pkg::AMP1_CTRL_OFFS, 8'hd3, 4'h1, resp);
      wr(opc_pkg::AMP2_CTRL_OFFS, 8'hd3, 4'h1, resp);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_cfg(cfg1, '0);
      chk_cfg(cfg2, '0);
      rd_reg(opc_pkg::AMP2_CTRL_OFFS, rd, resp);
      chk_data(rd, 32'h0000_0000);
      final_report();
   end
endmodule // tb_top
`default_nettype wire
